//--- design/isa_bus_timing_control.sv
// Purpose: ISA timing and control registers of a PCI to ISA bridge, reached over APB
// Assumes: all inputs synchronous to SYS_CLK; ISA clock derived by division
// Notes: registers are 8 bits in the low byte of each APB word
`include "isa_bus_timing_control_consts.svh"
`timescale 1ns/10ps
module isa_bus_timing_control #(
    parameter int APB_ADDR_W = 12
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire isa_bus_timing_control_pkg::io_cycle_end_t IO_END,
    output logic IO_RECOVERED,
    output logic ISA_BUS_CLOCK,
    output logic ISA_RESET_OUTPUT,
    input wire logic MOUSE_OR_IRQ12_PIN,
    output logic MOUSE_IRQ,
    output logic IRQ12,
    input wire logic COPROCESSOR_ERROR_INPUT_N,
    input wire logic IGNORE_REQUEST,
    output logic IRQ13,
    output logic IGNORE_NUMERIC_ERROR_OUTPUT_N,
    input wire logic PCI_MEM_VALID,
    input wire logic [31:0] PCI_MEM_ADDR,
    output logic BIOS_CHIP_SELECT_N,
    output logic UTILITY_BUS_OUTPUT_ENABLE_N,
    output logic BIOS_POSITIVE_CLAIM,
    input wire logic ISA_MEM_VALID,
    input wire logic [31:0] ISA_MEM_ADDR,
    output logic ISA_TO_PCI
);
    import isa_bus_timing_control_pkg::*;

    // ==========================================================
    // elaboration check
    generate
        // the register index is taken from address bits 9:2, so ten bits at least
        if (APB_ADDR_W < 10 || APB_ADDR_W > 32) begin : g_bad_width
            $error("APB_ADDR_W must lie between 10 and 32");
        end
    endgenerate

    // ==========================================================
    // register storage
    logic [7:0] top_of_memory;
    logic [7:0] hole_bottom_bound;
    logic [7:0] hole_top_bound;
    logic [7:0] isa_io_recovery_control;
    logic [7:0] isa_clock_divisor_control;
    logic [7:0] decode_ctrl;
    recovery_ctrl_t rec;
    divisor_ctrl_t divc;

    assign rec = recovery_ctrl_t'(isa_io_recovery_control);
    assign divc = divisor_ctrl_t'(isa_clock_divisor_control);

    // ==========================================================
    // APB decode
    wire setup_phase = PSEL & ~PENABLE;
    wire access_done = PSEL & PENABLE & PREADY;
    wire [7:0] reg_index = PADDR[9:2];
    wire word_aligned = (PADDR[1:0] == 2'h0);
    wire high_zero = (APB_ADDR_W <= 10) ? 1'b1 : (PADDR >> 10) == '0;
    wire hit_tom = reg_index == `IDX_TOP_OF_MEMORY;
    wire hit_boh = reg_index == `IDX_HOLE_BOTTOM;
    wire hit_toh = reg_index == `IDX_HOLE_TOP;
    wire hit_rec = reg_index == `IDX_RECOVERY;
    wire hit_div = reg_index == `IDX_DIVISOR;
    wire hit_dec = reg_index == `IDX_DECODE_CTRL;
    wire hit_sts = reg_index == `IDX_STATUS;
    wire hit_any = word_aligned & high_zero & (hit_tom | hit_boh | hit_toh | hit_rec | hit_div | hit_dec | hit_sts);
    wire wr_ok = access_done & PWRITE & hit_any & word_aligned & high_zero;
    wire [7:0] wbyte = PWDATA[7:0];

    // ==========================================================
    // read mux, status shows recovery and divider state
    logic rec_busy;
    logic [3:0] rec_cnt;
    wire [7:0] status_byte = {2'h0, rec_cnt, ISA_BUS_CLOCK, rec_busy};
    wire [7:0] read_byte =
        hit_tom ? top_of_memory :
        hit_boh ? hole_bottom_bound :
        hit_toh ? hole_top_bound :
        hit_rec ? (isa_io_recovery_control & `RECOVERY_RD_MASK) :
        hit_div ? isa_clock_divisor_control :
        hit_dec ? decode_ctrl :
        hit_sts ? status_byte : 8'h00;

    // no wait state: answer prepared in setup, taken in the first access cycle
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
        end else begin
            PREADY <= setup_phase;
            PSLVERR <= setup_phase & ~hit_any;
            PRDATA <= (setup_phase & ~PWRITE & hit_any) ? {24'h0, read_byte} : 32'h0;
        end
    end

    // ==========================================================
    // register writes
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            top_of_memory <= `RST_TOP_OF_MEMORY;
            hole_bottom_bound <= `RST_HOLE_BOTTOM;
            hole_top_bound <= `RST_HOLE_TOP;
            isa_io_recovery_control <= `RST_RECOVERY;
            isa_clock_divisor_control <= `RST_DIVISOR;
            decode_ctrl <= `RST_DECODE_CTRL;
        end else if (wr_ok) begin
            if (hit_tom) top_of_memory <= wbyte;
            if (hit_boh) hole_bottom_bound <= wbyte;
            if (hit_toh) hole_top_bound <= wbyte;
            if (hit_rec) isa_io_recovery_control <= wbyte & `RECOVERY_RD_MASK;
            if (hit_div) isa_clock_divisor_control <= wbyte;
            if (hit_dec) decode_ctrl <= wbyte;
        end
    end

    // ==========================================================
    // ISA clock divider; reserved codes fall back to divide by four
    logic [1:0] div_cnt;
    wire by3 = divc.divisor == `DIV_CODE_BY3;
    wire [1:0] div_last = by3 ? `DIV_LAST_BY3 : `DIV_LAST_BY4;
    wire div_wrap = div_cnt >= div_last;
    wire [1:0] next_div_cnt = div_wrap ? 2'h0 : div_cnt + 2'h1;
    wire next_isa_clk = (next_div_cnt == 2'h0) | (~by3 & next_div_cnt == 2'h1);
    wire isa_tick = div_wrap; // one pulse per ISA clock, at its rising edge

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            div_cnt <= 2'h0;
            ISA_BUS_CLOCK <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            ISA_BUS_CLOCK <= next_isa_clk;
        end
    end

    // ==========================================================
    // recovery length from the field matching the finished cycle
    wire [3:0] add8 = (rec.rec8 == 3'h0) ? `REC8_CODE0_ADD : {1'b0, rec.rec8};
    wire [3:0] add16 = (rec.rec16 == 2'h0) ? `REC16_CODE0_ADD : {2'h0, rec.rec16};
    wire [3:0] extra8 = rec.en8 ? add8 : 4'h0;
    wire [3:0] extra16 = rec.en16 ? add16 : 4'h0;
    wire [3:0] extra = IO_END.wide16 ? extra16 : extra8;
    wire [3:0] total = `REC_MIN_CLKS + extra;
    wire counted_end = IO_END.done & ~IO_END.subcycle;

    // ==========================================================
    // recovery counter, started at command end, ticking on ISA clocks
    rec_state_t state;
    rec_state_t next_state;
    logic [3:0] next_rec_cnt;

    always_comb begin
        next_state = state;
        next_rec_cnt = rec_cnt;
        case (state)
            REC_IDLE: begin
                if (counted_end) begin
                    next_state = REC_COUNT;
                    next_rec_cnt = total;
                end
            end
            REC_COUNT: begin
                if (counted_end) begin
                    next_rec_cnt = total;
                end else if (isa_tick) begin
                    next_rec_cnt = rec_cnt - 4'h1;
                    if (rec_cnt == 4'h1) begin
                        next_state = REC_IDLE;
                    end
                end
            end
            default: begin
                next_state = REC_IDLE;
                next_rec_cnt = 4'h0;
            end
        endcase
    end

    // the engine may drop the next address latch only while recovered
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state <= REC_IDLE;
            rec_cnt <= 4'h0;
            IO_RECOVERED <= 1'b1;
        end else begin
            state <= next_state;
            rec_cnt <= next_rec_cnt;
            IO_RECOVERED <= next_state == REC_IDLE;
        end
    end

    assign rec_busy = state == REC_COUNT;

    // ==========================================================
    // ISA reset, interrupt routing and coprocessor gating
    wire coprocessor_error_input_active = ~COPROCESSOR_ERROR_INPUT_N;
    wire next_irq13 = divc.coproc_en ? coprocessor_error_input_active : COPROCESSOR_ERROR_INPUT_N;
    wire next_ignore_numeric_error_output_n = ~(divc.coproc_en & coprocessor_error_input_active & IGNORE_REQUEST);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ISA_RESET_OUTPUT <= 1'b1;
            MOUSE_IRQ <= 1'b0;
            IRQ12 <= 1'b0;
            IRQ13 <= 1'b0;
            IGNORE_NUMERIC_ERROR_OUTPUT_N <= 1'b1;
        end else begin
            ISA_RESET_OUTPUT <= divc.isa_reset;
            MOUSE_IRQ <= divc.mouse_en & MOUSE_OR_IRQ12_PIN;
            IRQ12 <= ~divc.mouse_en & MOUSE_OR_IRQ12_PIN;
            IRQ13 <= next_irq13;
            IGNORE_NUMERIC_ERROR_OUTPUT_N <= next_ignore_numeric_error_output_n;
        end
    end

    // ==========================================================
    // upper BIOS decode for PCI accesses
    wire [15:0] pci_blk = PCI_MEM_ADDR[31:16];
    wire bios_hit = PCI_MEM_VALID & ((pci_blk == `BIOS_UPPER_64K) |
        (pci_blk == `BIOS_ALIAS_4G) | (pci_blk == `BIOS_ALIAS_4G_1M));
    wire force_subtractive = decode_ctrl[4];
    wire next_claim = bios_hit & divc.bios_positive & ~force_subtractive;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            BIOS_CHIP_SELECT_N <= 1'b1;
            UTILITY_BUS_OUTPUT_ENABLE_N <= 1'b1;
            BIOS_POSITIVE_CLAIM <= 1'b0;
        end else begin
            BIOS_CHIP_SELECT_N <= ~bios_hit;
            UTILITY_BUS_OUTPUT_ENABLE_N <= ~bios_hit;
            BIOS_POSITIVE_CLAIM <= next_claim;
        end
    end

    // ==========================================================
    // ISA master and DMA forwarding to PCI
    wire upper_zero = ISA_MEM_ADDR[31:24] == 8'h00;
    wire [7:0] blk64k = ISA_MEM_ADDR[23:16];
    wire [4:0] tom_units = {1'b0, top_of_memory[7:4]} + 5'h1;
    wire [4:0] addr_mb = {1'b0, ISA_MEM_ADDR[23:20]};
    wire above_1m = blk64k >= `ONE_MB_UNIT;
    wire below_tom = addr_mb < tom_units;
    wire hole_on = hole_top_bound >= hole_bottom_bound;
    wire in_hole = hole_on & (blk64k >= hole_bottom_bound) & (blk64k <= hole_top_bound);
    wire low_fwd = upper_zero & above_1m & below_tom & ~in_hole;
    wire next_fwd = ISA_MEM_VALID & (~upper_zero | low_fwd);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ISA_TO_PCI <= 1'b0;
        end else begin
            ISA_TO_PCI <= next_fwd;
        end
    end

endmodule

//--- design/isa_bus_timing_control_consts.svh
// Purpose: offsets, field codes, reset values and counts of the ISA timing block
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef ISA_BUS_TIMING_CONTROL_CONSTS_SVH
`define ISA_BUS_TIMING_CONTROL_CONSTS_SVH

// ==========================================================
// register indices
`define IDX_TOP_OF_MEMORY 8'h48
`define IDX_HOLE_BOTTOM 8'h4a
`define IDX_HOLE_TOP 8'h4b
`define IDX_RECOVERY 8'h4c
`define IDX_DIVISOR 8'h4d
`define IDX_DECODE_CTRL 8'h60
`define IDX_STATUS 8'h61

// ==========================================================
// reset values
`define RST_TOP_OF_MEMORY 8'h01
`define RST_HOLE_BOTTOM 8'h10
`define RST_HOLE_TOP 8'h0f
`define RST_RECOVERY 8'h56
`define RST_DIVISOR 8'h40
`define RST_DECODE_CTRL 8'h00

// ==========================================================
// field codes and masks
`define RECOVERY_RD_MASK 8'h7f
`define DIV_CODE_BY4 3'h0
`define DIV_CODE_BY3 3'h1
`define DIV_LAST_BY4 2'h3
`define DIV_LAST_BY3 2'h2
`define REC_MIN_CLKS 4'h4
`define REC8_CODE0_ADD 4'h8
`define REC16_CODE0_ADD 4'h4

// ==========================================================
// address map pieces, in 64 KB units
`define BIOS_UPPER_64K 16'h000f
`define BIOS_ALIAS_4G 16'hffff
`define BIOS_ALIAS_4G_1M 16'hffef
`define ONE_MB_UNIT 8'h10

`endif

//--- design/isa_bus_timing_control_pkg.sv
// Purpose: types shared by the ISA timing block
// Assumes: nothing
// Notes: field layouts of the two documented control bytes
package isa_bus_timing_control_pkg;

    // ==========================================================
    // recovery control byte
    typedef struct packed {
        logic reserved;
        logic en8;
        logic [2:0] rec8;
        logic en16;
        logic [1:0] rec16;
    } recovery_ctrl_t;

    // ==========================================================
    // clock divisor control byte
    typedef struct packed {
        logic reserved;
        logic bios_positive;
        logic coproc_en;
        logic mouse_en;
        logic isa_reset;
        logic [2:0] divisor;
    } divisor_ctrl_t;

    // ==========================================================
    // completed I/O cycle report from the ISA cycle engine
    typedef struct packed {
        logic done;
        logic wide16;
        logic subcycle;
    } io_cycle_end_t;

    typedef enum logic {
        REC_IDLE,
        REC_COUNT
    } rec_state_t;

endpackage

//--- testbench/isa_timing_asserts.sv
// Purpose: assertions on the ports of the ISA timing block
// Assumes: one clock, SRST synchronous and active high
// Notes: bound to the design at the foot of this file
`timescale 1ns/10ps
module isa_timing_asserts
    import isa_bus_timing_control_pkg::*;
#(
    parameter int APB_ADDR_W = 12
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PWRITE,
    input wire logic [APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire isa_bus_timing_control_pkg::io_cycle_end_t IO_END,
    input wire logic IO_RECOVERED,
    input wire logic ISA_BUS_CLOCK,
    input wire logic ISA_RESET_OUTPUT,
    input wire logic COPROCESSOR_ERROR_INPUT_N,
    input wire logic IGNORE_REQUEST,
    input wire logic IGNORE_NUMERIC_ERROR_OUTPUT_N,
    input wire logic PCI_MEM_VALID,
    input wire logic [31:0] PCI_MEM_ADDR,
    input wire logic BIOS_CHIP_SELECT_N,
    input wire logic UTILITY_BUS_OUTPUT_ENABLE_N,
    input wire logic BIOS_POSITIVE_CLAIM,
    input wire logic ISA_MEM_VALID,
    input wire logic [31:0] ISA_MEM_ADDR,
    input wire logic ISA_TO_PCI
);
    // ====
    // recovery
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    sequence s_cmd_end;
        IO_END.done && !IO_END.subcycle;
    endsequence
    sequence s_sub_end;
        IO_END.done && IO_END.subcycle && IO_RECOVERED;
    endsequence
    property p_rec_start;
        s_cmd_end |=> !IO_RECOVERED;
    endproperty
    a_rec_start: assert property (p_rec_start) else $error("recovery did not start");
    property p_rec_min;
        $fell(IO_RECOVERED) |-> !IO_RECOVERED [*8];
    endproperty
    a_rec_min: assert property (p_rec_min) else $error("recovery too short");
    property p_sub_free;
        s_sub_end |=> IO_RECOVERED;
    endproperty
    a_sub_free: assert property (p_sub_free) else $error("sub-cycle delayed");
    // ====
    // registers and clock
    property p_bit7;
        PREADY && !PWRITE && PADDR == APB_ADDR_W'('h130) |-> !PRDATA[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("reserved bit read as one");
    property p_clk_high;
        $rose(ISA_BUS_CLOCK) |=> ##[0:1] !ISA_BUS_CLOCK;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("isa clock high too long");
    property p_rst_drv;
        $fell(SRST) |-> ISA_RESET_OUTPUT;
    endproperty
    a_rst_drv: assert property (p_rst_drv) else $error("isa reset not driven in reset");
    // ====
    // decoders
    property p_ignore_numeric_error_output;
        !IGNORE_NUMERIC_ERROR_OUTPUT_N |-> $past(!COPROCESSOR_ERROR_INPUT_N && IGNORE_REQUEST);
    endproperty
    a_ignore_numeric_error_output: assert property (p_ignore_numeric_error_output) else $error("ignore output without error");
    property p_bios_cs;
        PCI_MEM_VALID && PCI_MEM_ADDR[31:16] == 16'hffff |=> !BIOS_CHIP_SELECT_N && !UTILITY_BUS_OUTPUT_ENABLE_N;
    endproperty
    a_bios_cs: assert property (p_bios_cs) else $error("bios select missing");
    property p_claim;
        BIOS_POSITIVE_CLAIM |-> !BIOS_CHIP_SELECT_N;
    endproperty
    a_claim: assert property (p_claim) else $error("claim outside bios range");
    property p_fwd_high;
        ISA_MEM_VALID && ISA_MEM_ADDR[31:24] != 8'h00 |=> ISA_TO_PCI;
    endproperty
    a_fwd_high: assert property (p_fwd_high) else $error("high address not forwarded");
endmodule

bind isa_bus_timing_control isa_timing_asserts #(.APB_ADDR_W(APB_ADDR_W)) u_isa_timing_asserts (
    .SYS_CLK, .SRST, .PWRITE, .PADDR, .PRDATA, .PREADY, .IO_END, .IO_RECOVERED, .ISA_BUS_CLOCK,
    .ISA_RESET_OUTPUT, .COPROCESSOR_ERROR_INPUT_N, .IGNORE_REQUEST, .IGNORE_NUMERIC_ERROR_OUTPUT_N,
    .PCI_MEM_VALID, .PCI_MEM_ADDR, .BIOS_CHIP_SELECT_N, .UTILITY_BUS_OUTPUT_ENABLE_N,
    .BIOS_POSITIVE_CLAIM, .ISA_MEM_VALID, .ISA_MEM_ADDR, .ISA_TO_PCI
);

//--- testbench/isa_io_engine_model.sv
// Purpose: ISA cycle engine stand-in reporting command ends
// Assumes: the bench calls its task right after a clock edge
// Notes: done is a one-cycle pulse
`timescale 1ns/10ps
module isa_io_engine_model
    import isa_bus_timing_control_pkg::*;
(
    input wire logic clk,
    output isa_bus_timing_control_pkg::io_cycle_end_t io_end
);
    // idle until a cycle ends
    initial io_end = '0;
    // command or sub-cycle ends here; recovery counts from it only when sub is low
    task automatic finish_cycle(input logic wide, input logic sub);
        @(posedge clk) io_end <= '{done: 1'b1, wide16: wide, subcycle: sub};
        @(posedge clk) io_end <= '0;
    endtask
endmodule

//--- testbench/test_isa_bus_timing_control.sv
// Purpose: self-checking bench of the ISA timing block
// Assumes: APB answers in the access cycle
// Notes: recovery length counted in ISA clock rises
`timescale 1ns/10ps
module test_isa_bus_timing_control;
    import isa_bus_timing_control_pkg::*;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, e, rec, isa_clk, isa_rst;
    logic m_in = 0, m_irq, irq12, coprocessor_error_input_n = 1, ign = 0, irq13, ignore_numeric_error_output_n, pci_v = 0, bcs_n, ub_n;
    logic claim, isa_v = 0, to_pci, prev;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, pci_a = '0, isa_a = '0;
    io_cycle_end_t io_end;
    int err_count = 0, n_compared = 0, n, k;
    typedef struct {logic [7:0] rec; logic [7:0] div; logic w; int n;} row_t;
    row_t rows[11] = '{'{8'h56, 8'h40, 0, 6}, '{8'h56, 8'h40, 1, 6}, '{8'h48, 8'h40, 0, 5},
        '{8'h78, 8'h40, 0, 11}, '{8'h40, 8'h40, 0, 12}, '{8'h00, 8'h40, 0, 4}, '{8'h00, 8'h40, 1, 4},
        '{8'h04, 8'h40, 1, 8}, '{8'h07, 8'h40, 1, 7}, '{8'h78, 8'h40, 1, 4}, '{8'h05, 8'h41, 1, 5}};
    logic [32:0] hole[5] = '{33'h0_00f0ffff, 33'h1_00f10000, 33'h1_00efffff, 33'h1_00ffffff, 33'h1_01000000};

    isa_bus_timing_control u_isa_bus_timing_control (.SYS_CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(perr), .IO_END(io_end), .IO_RECOVERED(rec), .ISA_BUS_CLOCK(isa_clk),
        .ISA_RESET_OUTPUT(isa_rst), .MOUSE_OR_IRQ12_PIN(m_in), .MOUSE_IRQ(m_irq), .IRQ12(irq12),
        .COPROCESSOR_ERROR_INPUT_N(coprocessor_error_input_n), .IGNORE_REQUEST(ign), .IRQ13(irq13),
        .IGNORE_NUMERIC_ERROR_OUTPUT_N(ignore_numeric_error_output_n), .PCI_MEM_VALID(pci_v), .PCI_MEM_ADDR(pci_a),
        .BIOS_CHIP_SELECT_N(bcs_n), .UTILITY_BUS_OUTPUT_ENABLE_N(ub_n), .BIOS_POSITIVE_CLAIM(claim),
        .ISA_MEM_VALID(isa_v), .ISA_MEM_ADDR(isa_a), .ISA_TO_PCI(to_pci));
    isa_io_engine_model u_isa_io_engine_model (.clk(clk), .io_end(io_end));

    // ====
    // clock and helpers
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("TB: %0d compared, %0d mismatched", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) pen <= 1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1 && t < 20);
        if (t == 20) err_count++;
        if (t == 20) tally_and_finish();
        q = prdata;
        e = perr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // one completed cycle, then ISA clock rises until recovered
    task automatic measure(input logic w, input logic sub);
        u_isa_io_engine_model.finish_cycle(w, sub);
        #1 prev = isa_clk;
        n = 0;
        for (k = 0; k < 300 && rec !== 1; k++) begin
            @(posedge clk);
            #1 n += int'(isa_clk && !prev);
            prev = isa_clk;
        end
        // a recovery that never ends counts as a mismatch
        if (k == 300) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // ====
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        srst <= 0;
        apb(0, 12'h130, 0);
        chk(q, 32'h56);
        apb(0, 12'h134, 0);
        chk(q, 32'h40);
        chk(isa_rst, 0);
        apb(1, 12'h130, 32'hff);
        apb(0, 12'h130, 0);
        chk(q, 32'h7f);
        apb(0, 12'h004, 0);
        chk(e, 1);
        $display("TB: register test done");
        foreach (rows[i]) begin
            apb(1, 12'h134, rows[i].div); // only the defined divisor codes are used
            apb(1, 12'h130, rows[i].rec);
            measure(rows[i].w, 0);
            chk(n, rows[i].n);
            $display("TB: recovery row %0d done", i);
        end
        measure(0, 1);
        chk(n, 0);
        // divide by three gives eight rises in 24 cycles
        n = 0;
        for (k = 0; k < 24; k++) begin
            @(posedge clk);
            #1 n += int'(isa_clk && !prev);
            prev = isa_clk;
        end
        chk(n, 8);
        apb(1, 12'h134, 32'h08);
        settle();
        chk(isa_rst, 1);
        repeat (100) @(posedge clk);
        apb(1, 12'h134, 32'h30);
        @(posedge clk) {m_in, coprocessor_error_input_n, ign, pci_v, pci_a} <= {3'b101, 1'b1, 32'h000f0000};
        settle();
        chk({isa_rst, m_irq, irq12, irq13, ignore_numeric_error_output_n}, 5'b01010);
        chk({bcs_n, ub_n, claim}, 3'b000);
        apb(1, 12'h134, 32'h40);
        settle();
        chk({m_irq, irq12, irq13, ignore_numeric_error_output_n, claim}, 5'b01011);
        apb(1, 12'h180, 32'h10);
        settle();
        chk({bcs_n, claim}, 2'b00);
        $display("TB: control test done");
        apb(1, 12'h120, 32'hf0);
        apb(1, 12'h128, 32'hf0);
        apb(1, 12'h12c, 32'hf0);
        foreach (hole[i]) begin
            @(posedge clk) {isa_v, isa_a} <= {1'b1, hole[i][31:0]};
            settle();
            chk(to_pci, hole[i][32]);
        end
        $display("TB: decode test done");
        // reset in mid-run brings the outputs and registers back to their reset state
        @(posedge clk) srst <= 1;
        settle();
        chk({isa_rst, rec, to_pci}, 3'b110);
        repeat (8) @(posedge clk);
        srst <= 0;
        apb(0, 12'h134, 0);
        chk(q, 32'h40);
        apb(0, 12'h130, 0);
        chk(q, 32'h56);
        $display("TB: mid-run reset test done");
        tally_and_finish();
    end
endmodule
